// ===== rtl/dsadc_regs.vh
`ifndef DSADC_REGS_VH
`define DSADC_REGS_VH

// Clock rates and the derived divider down to the operation clock.
`define DSADC_SYS_CLK_MHZ 100
`define DSADC_OP_CLK_MHZ 10
`define DSADC_OP_DIV (`DSADC_SYS_CLK_MHZ / `DSADC_OP_CLK_MHZ)

// Oversampling: 10 MHz / 18 = 555.6 kHz, split into two modulator slots.
`define DSADC_OS_OP_CLKS 18
`define DSADC_SLOT_OP_CLKS (`DSADC_OS_OP_CLKS / 2)

// Decimation ratio and the resulting 4.340 kHz output period.
`define DSADC_DEC_RATIO 128
`define DSADC_DEC_LAST 7'h7F
`define DSADC_DEC_MID 8'h40

// Phase adjustment range in oversampling steps.
`define DSADC_PHASE_MAX 255
`define DSADC_DLINE_DEPTH 256

// DC-removal filter pole as a right shift.
`define DSADC_HPF_SHIFT 8

// Result width and reset value.
`define DSADC_RES_W 24
`define DSADC_RES_RESET 24'h000000
`define DSADC_RES_POS_MAX 24'h7FFFFF
`define DSADC_RES_NEG_MAX 24'h800000

// Pair roles, bit n for input pair n.
`define DSADC_ACTIVE_2W 4'h7
`define DSADC_CURRENT_2W 4'h6
`define DSADC_ACTIVE_3W 4'hF
`define DSADC_CURRENT_3W 4'hA

`endif

// ===== rtl/dsadc_fifo.v
`timescale 1ns/1ns
module dsadc_fifo #(
    parameter WIDTH = 26,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    input wire flush,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ===== rtl/dsadc_top.v
// How it works
// R01: two lockstep modulators, each serving two channels
// R02: channels 0,2 unity; 1,3 gain two/sixteen
// R03: 10 MHz op clock, 555.6 kHz oversampling
// R04: decimate by 128, one word per period
// R05: per-channel delay up to 255 oversample steps
// R06: DC-removal filter per channel, independently selectable
// R07: two-wire: voltage, current1, current2, pair3 unused
// R08: three-wire: V1, I1, V2, I2; four-channel only
// R09: pair first pin negative, second pin positive
// R10: host must supply the 10 MHz clock
// R11: each channel has a 24-bit result register
// R12: reference internal bandgap out or external in
// R13: source select 1 stops bandgap, pin input
// R14: results zero on reset and while disabled
// R15: bypass bit 0 inserts filter, 1 passes
// R16: each period, update enabled channel results; a full FIFO stalls updates and periods ending meanwhile are dropped
`timescale 1ns/1ns
`include "dsadc_regs.vh"
module dsadc_top #(
    parameter FOUR_CH_VARIANT = 1,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Control
    input wire conversion_enable_bit,
    input wire wire_mode_select,
    input wire reference_source_select,
    input wire gain_select_16,
    input wire [3:0] filter_bypass_bit,
    input wire [31:0] phase_shift_setting,
    // Modulator bitstreams and slot control
    input wire mod_a_bit,
    input wire mod_b_bit,
    output wire mod_slot,
    output wire pga_gain_16,
    // Pair roles for the analog front-end
    output wire [3:0] pair_active,
    output wire [3:0] pair_is_current,
    // Reference pin and bandgap
    input wire reference_io_pin_i,
    output wire reference_io_pin_o,
    output wire reference_io_pin_oe,
    output wire bandgap_enable,
    output wire reference_external_seen,
    // Results
    output wire [95:0] channel_result_registers,
    output wire sample_overrun,
    // Result stream
    output wire result_valid,
    input wire result_ready,
    output wire [1:0] result_channel,
    output wire [23:0] result_data
);
    reg [3:0] div_q;
    reg [3:0] slot_cnt_q;
    reg slot_q;
    reg [3:0] bits_q;
    reg [7:0] wp_q;
    reg [6:0] dec_cnt_q;
    reg [7:0] acc_q [0:3];
    reg [31:0] hold_q;
    reg [95:0] dc_q;
    reg [95:0] results_q;
    reg seq_busy_q;
    reg [1:0] seq_ch_q;
    reg overrun_q;
    reg [3:0] dline [0:`DSADC_DLINE_DEPTH-1];
    reg [3:0] tap_bits;
    integer c;
    integer t;

    wire op_tick;
    wire slot_end;
    wire os_tick;
    wire [3:0] os_bits;
    wire dec_end;
    wire three_wire;
    wire fifo_in_ready;
    wire [7:0] cur_sum;
    wire [7:0] centered;
    wire [23:0] raw;
    wire [23:0] dc_cur;
    wire [24:0] hp_wide;
    wire signed [23:0] hp;
    wire [23:0] dc_step;
    wire [23:0] out_val;
    wire ch_active;
    wire seq_go;

    function [7:0] tap_addr;
        input [7:0] wp;
        input [7:0] ph;
        begin
            tap_addr = wp - ph;
        end
    endfunction

    function [23:0] sat24;
        input [24:0] v;
        begin
            if (v[24] == 1'b0 && v[23] == 1'b1) begin
                sat24 = `DSADC_RES_POS_MAX;
            end else if (v[24] == 1'b1 && v[23] == 1'b0) begin
                sat24 = `DSADC_RES_NEG_MAX;
            end else begin
                sat24 = v[23:0];
            end
        end
    endfunction

    // R10: op clock assumed
    // The host owns the 10 MHz routing; this divider assumes it is there.
    // R03: op clock tick
    assign op_tick = (div_q == `DSADC_OP_DIV - 1);
    assign slot_end = op_tick && (slot_cnt_q == `DSADC_SLOT_OP_CLKS - 1);
    // R03: oversample tick
    assign os_tick = slot_end && slot_q;
    // R01: time-shared modulators
    // Modulator A carries channels 0/1 and B carries 2/3; slot 1 completes
    // the set so all four bits enter the delay line together.
    assign os_bits = {mod_b_bit, bits_q[2], mod_a_bit, bits_q[0]};
    assign mod_slot = slot_q;
    // R09: bit polarity
    // A one bit means the second (positive) pin is above the first.
    // R02: gain select
    assign pga_gain_16 = gain_select_16;

    // R08: three-wire gate
    assign three_wire = wire_mode_select && (FOUR_CH_VARIANT != 0);
    // R07: pair roles
    assign pair_active = three_wire ? `DSADC_ACTIVE_3W : `DSADC_ACTIVE_2W;
    assign pair_is_current = three_wire ? `DSADC_CURRENT_3W :
        `DSADC_CURRENT_2W;

    // R13: reference direction
    assign bandgap_enable = !reference_source_select;
    assign reference_io_pin_oe = !reference_source_select;
    // R12: reference sources
    assign reference_io_pin_o = 1'b1;
    assign reference_external_seen = reference_source_select &&
        reference_io_pin_i;

    // R05: phase taps
    // Delay zero bypasses the line so the newest bit is used directly.
    always @* begin
        tap_bits = 4'h0;
        for (t = 0; t < 4; t = t + 1) begin
            if (phase_shift_setting[t*8 +: 8] == 8'h00) begin
                tap_bits[t] = os_bits[t];
            end else begin
                tap_bits[t] = dline[tap_addr(wp_q,
                    phase_shift_setting[t*8 +: 8])][t];
            end
        end
    end

    always @(posedge clk_sys) begin
        if (os_tick) begin
            dline[wp_q] <= os_bits;
        end
    end

    // R04: decimation boundary
    assign dec_end = os_tick && (dec_cnt_q == `DSADC_DEC_LAST);

    // R16: sequencer datapath
    assign cur_sum = hold_q[{seq_ch_q, 3'b000} +: 8];
    assign centered = cur_sum - `DSADC_DEC_MID;
    assign raw = {centered, 16'h0000};
    assign dc_cur = dc_q[seq_ch_q*24 +: 24];
    assign hp_wide = {raw[23], raw} - {dc_cur[23], dc_cur};
    assign hp = sat24(hp_wide);
    assign dc_step = hp >>> `DSADC_HPF_SHIFT;
    // R15: bypass polarity
    assign out_val = filter_bypass_bit[seq_ch_q] ? raw : hp;
    assign ch_active = pair_active[seq_ch_q];
    // Inactive pairs need no FIFO space, so only active ones wait on it.
    assign seq_go = seq_busy_q && (fifo_in_ready || !ch_active);

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_q <= 4'h0;
            slot_cnt_q <= 4'h0;
            slot_q <= 1'b0;
            bits_q <= 4'h0;
            wp_q <= 8'h00;
            dec_cnt_q <= 7'h00;
            hold_q <= 32'h00000000;
            dc_q <= 96'h0;
            results_q <= 96'h0;
            seq_busy_q <= 1'b0;
            seq_ch_q <= 2'h0;
            overrun_q <= 1'b0;
            for (c = 0; c < 4; c = c + 1) begin
                acc_q[c] <= 8'h00;
            end
        end else if (!conversion_enable_bit) begin
            // R14: held cleared
            // The delay line memory is not cleared; stale bits may feed
            // the first 255 oversamples after enabling.
            div_q <= 4'h0;
            slot_cnt_q <= 4'h0;
            slot_q <= 1'b0;
            bits_q <= 4'h0;
            wp_q <= 8'h00;
            dec_cnt_q <= 7'h00;
            hold_q <= 32'h00000000;
            dc_q <= 96'h0;
            results_q <= 96'h0;
            seq_busy_q <= 1'b0;
            seq_ch_q <= 2'h0;
            overrun_q <= 1'b0;
            for (c = 0; c < 4; c = c + 1) begin
                acc_q[c] <= 8'h00;
            end
        end else begin
            div_q <= op_tick ? 4'h0 : div_q + 4'h1;
            if (op_tick) begin
                slot_cnt_q <= slot_end ? 4'h0 : slot_cnt_q + 4'h1;
            end
            if (slot_end) begin
                slot_q <= !slot_q;
                if (!slot_q) begin
                    bits_q[0] <= mod_a_bit;
                    bits_q[2] <= mod_b_bit;
                end
            end
            if (os_tick) begin
                wp_q <= wp_q + 8'h01;
                dec_cnt_q <= dec_cnt_q + 7'h01;
                // R04: boxcar accumulate
                for (c = 0; c < 4; c = c + 1) begin
                    if (dec_end) begin
                        acc_q[c] <= 8'h00;
                    end else begin
                        acc_q[c] <= acc_q[c] + {7'h00, tap_bits[c]};
                    end
                end
            end
            if (seq_go) begin
                if (ch_active) begin
                    // R06: DC removal
                    dc_q[seq_ch_q*24 +: 24] <= dc_cur + dc_step;
                    // R11: result store
                    results_q[seq_ch_q*24 +: 24] <= out_val;
                end
                seq_ch_q <= seq_ch_q + 2'h1;
                if (seq_ch_q == 2'h3) begin
                    seq_busy_q <= 1'b0;
                end
            end
            // R16: period snapshot
            // A full FIFO stalls the sequencer; a period that ends while it
            // is still stalled is dropped and flagged rather than torn.
            if (dec_end) begin
                if (seq_busy_q && !(seq_go && seq_ch_q == 2'h3)) begin
                    overrun_q <= 1'b1;
                end else begin
                    seq_busy_q <= 1'b1;
                    seq_ch_q <= 2'h0;
                    for (c = 0; c < 4; c = c + 1) begin
                        hold_q[c*8 +: 8] <= acc_q[c] + {7'h00, tap_bits[c]};
                    end
                end
            end
        end
    end

    assign channel_result_registers = results_q;
    assign sample_overrun = overrun_q;

    dsadc_fifo #(
        .WIDTH(26),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .flush(!conversion_enable_bit),
        .in_valid(seq_busy_q && ch_active),
        .in_ready(fifo_in_ready),
        .in_data({seq_ch_q, out_val}),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data({result_channel, result_data})
    );
endmodule

// ===== testbench/dsadc_checker_properties.sv
`timescale 1ns/1ns
module dsadc_checker (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Control
    input wire conversion_enable_bit,
    input wire wire_mode_select,
    input wire reference_source_select,
    input wire gain_select_16,
    input wire result_ready,
    // Observed outputs
    input wire mod_slot,
    input wire pga_gain_16,
    input wire [3:0] pair_active,
    input wire [3:0] pair_is_current,
    input wire reference_io_pin_oe,
    input wire bandgap_enable,
    input wire [95:0] channel_result_registers,
    input wire result_valid,
    input wire [1:0] result_channel,
    input wire [23:0] result_data
);
    reg slot_q;
    reg [7:0] gap_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // The first slot after enable may be off by a cycle, hence the window.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slot_q <= 1'b0;
            gap_q <= 8'h00;
        end else begin
            slot_q <= mod_slot;
            if (mod_slot != slot_q || !conversion_enable_bit)
                gap_q <= 8'h00;
            else
                gap_q <= gap_q + 8'h01;
        end
    end
    sequence s_stall;
        result_valid && !result_ready && conversion_enable_bit
            ##1 conversion_enable_bit;
    endsequence
    property p_active;
        pair_active == (wire_mode_select ? 4'hF : 4'h7);
    endproperty
    property p_current;
        pair_is_current == (wire_mode_select ? 4'hA : 4'h6);
    endproperty
    property p_ref_oe;
        reference_io_pin_oe == !reference_source_select;
    endproperty
    property p_bandgap;
        bandgap_enable == !reference_source_select;
    endproperty
    property p_gain;
        pga_gain_16 == gain_select_16;
    endproperty
    property p_clear;
        !conversion_enable_bit |=>
            channel_result_registers == 96'h0 && !result_valid;
    endproperty
    property p_hold;
        s_stall |-> result_valid && $stable(result_data)
            && $stable(result_channel);
    endproperty
    property p_slot_len;
        mod_slot != slot_q && conversion_enable_bit
            && $past(conversion_enable_bit) |->
            gap_q >= 8'h58 && gap_q <= 8'h5C;
    endproperty
    property p_no_ch3;
        result_valid && !wire_mode_select |-> result_channel != 2'h3;
    endproperty
    a_active: assert property (p_active) else $error("pair roles");
    a_current: assert property (p_current) else $error("kinds");
    a_ref_oe: assert property (p_ref_oe) else $error("pin drive");
    a_bandgap: assert property (p_bandgap) else $error("bandgap");
    a_gain: assert property (p_gain) else $error("gain");
    a_clear: assert property (p_clear) else $error("not cleared");
    a_hold: assert property (p_hold) else $error("word moved");
    a_slot_len: assert property (p_slot_len) else $error("slot");
    a_no_ch3: assert property (p_no_ch3) else $error("pair three");
endmodule
bind dsadc_top dsadc_checker u_chk (.clk_sys, .resetn,
    .conversion_enable_bit, .wire_mode_select, .reference_source_select,
    .gain_select_16, .result_ready, .mod_slot, .pga_gain_16, .pair_active,
    .pair_is_current, .reference_io_pin_oe, .bandgap_enable,
    .channel_result_registers, .result_valid, .result_channel,
    .result_data);

// ===== testbench/dsadc_frontend_model.sv
`timescale 1ns/1ns
module dsadc_frontend_model (
    // Slot and sensor levels
    input wire mod_slot,
    input wire [3:0] ch_ones,
    // Reference pin from the converter
    input wire reference_io_pin_o,
    input wire reference_io_pin_oe,
    // To the converter
    output wire mod_a_bit,
    output wire mod_b_bit,
    output wire reference_io_pin_i
);
    assign mod_a_bit = mod_slot ? ch_ones[1] : ch_ones[0];
    assign mod_b_bit = mod_slot ? ch_ones[3] : ch_ones[2];
    // external source holds the pin high when not driven.
    assign reference_io_pin_i = reference_io_pin_oe ? reference_io_pin_o :
        1'b1;
endmodule

// ===== testbench/delta_sigma_adc_digital_path_test.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
$display("wrong value at %0t: %h vs %h", $time, g, e); end end
module delta_sigma_adc_digital_path_test;
    reg clk_sys = 1'b0;
    reg resetn = 1'b0;
    reg en = 1'b0, wmode = 1'b0, refsel = 1'b0, g16 = 1'b0, rdy = 1'b0;
    reg [3:0] byp = 4'hF;
    reg [3:0] lvl = 4'h5;
    reg [31:0] ph = 32'h0;
    wire mod_a, mod_b, slot, g16o, pin_i, pin_o, pin_oe, bg, ext, ovr, rv;
    wire [3:0] act, cur;
    wire [95:0] res;
    wire [1:0] rch;
    wire [23:0] rd;
    integer mismatches = 0, n_compared = 0;
    dsadc_top #(.FOUR_CH_VARIANT(1)) uut (.clk_sys(clk_sys), .resetn(resetn),
        .conversion_enable_bit(en), .wire_mode_select(wmode),
        .reference_source_select(refsel), .gain_select_16(g16),
        .filter_bypass_bit(byp), .phase_shift_setting(ph), .mod_a_bit(mod_a),
        .mod_b_bit(mod_b), .mod_slot(slot), .pga_gain_16(g16o),
        .pair_active(act), .pair_is_current(cur), .reference_io_pin_i(pin_i),
        .reference_io_pin_o(pin_o), .reference_io_pin_oe(pin_oe),
        .bandgap_enable(bg), .reference_external_seen(ext),
        .channel_result_registers(res), .sample_overrun(ovr),
        .result_valid(rv), .result_ready(rdy), .result_channel(rch),
        .result_data(rd));
    dsadc_frontend_model fe (.mod_slot(slot), .ch_ones(lvl),
        .reference_io_pin_o(pin_o), .reference_io_pin_oe(pin_oe),
        .mod_a_bit(mod_a), .mod_b_bit(mod_b), .reference_io_pin_i(pin_i));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    function [23:0] expv(input integer c, input m);
        expv = (c == 3 && !m) ? 24'h0 : (lvl[c] ? 24'h400000 : 24'hC00000);
    endfunction
    // Second period with the DC filter in: x minus the first x shifted by 8.
    function [23:0] fexp(input integer c);
        if (byp[c])
            fexp = expv(c, 1'b1);
        else
            fexp = lvl[c] ? 24'h3FC000 : 24'hC04000;
    endfunction
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task t_reset_state;
        begin
            #1;
            `CHK({res, rv, slot, ovr}, 99'h0)
        end
    endtask
    task t_pins;
        integer i;
        begin
            for (i = 0; i < 4; i++) begin
                @(posedge clk_sys);
                {wmode, refsel} <= i[1:0];
                g16 <= i[0];
                @(posedge clk_sys);
                #1;
                `CHK(act, wmode ? 4'hF : 4'h7)
                `CHK(cur, wmode ? 4'hA : 4'h6)
                `CHK({pin_oe, bg}, {2{!refsel}})
                `CHK(ext, refsel)
                `CHK(pin_o, 1'b1)
                `CHK(g16o, g16)
            end
        end
    endtask
    task t_period(input m, input integer nw);
        integer k, c;
        begin
            @(posedge clk_sys);
            wmode <= m;
            refsel <= 1'b0;
            en <= 1'b1;
            k = 0;
            while (rv !== 1'b1 && k < 24000) begin
                @(posedge clk_sys);
                #1;
                k++;
            end
            `CHK(k > 23035 && k < 23050, 1'b1)
            repeat (6) @(posedge clk_sys);
            #1;
            for (c = 0; c < 4; c++)
                `CHK(res[24*c +: 24], expv(c, m))
            @(posedge clk_sys);
            rdy <= 1'b1;
            for (c = 0; c < nw; c++) begin
                #1;
                `CHK({rv, rch, rd}, {1'b1, c[1:0], expv(c, m)})
                @(posedge clk_sys);
            end
            rdy <= 1'b0;
            #1;
            `CHK(rv, 1'b0)
            @(posedge clk_sys);
            en <= 1'b0;
            @(posedge clk_sys);
            #1;
            `CHK({res, rv}, 97'h0)
        end
    endtask
    task t_filter;
        integer c;
        begin
            @(posedge clk_sys);
            wmode <= 1'b1;
            lvl <= 4'h9;
            byp <= 4'hA;
            ph <= 32'h00000500;
            en <= 1'b1;
            // The DC estimate only moves after the first period, so the
            // filtered values are judged in the second one.
            repeat (2 * 128 * 180 + 8) @(posedge clk_sys);
            #1;
            for (c = 0; c < 4; c++)
                `CHK(res[24*c +: 24], fexp(c))
            `CHK({ovr, rv}, 2'b01)
            `CHK({rch, rd}, {2'h0, 24'h400000})
            @(posedge clk_sys);
            en <= 1'b0;
            @(posedge clk_sys);
            #1;
            `CHK({res, rv, ovr}, 98'h0)
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset_state;
        t_pins;
        t_period(1'b1, 4);
        lvl <= 4'hA;
        t_period(1'b0, 3);
        t_filter;
        give_verdict;
    end
    initial begin
        #960000;
        mismatches++;
        give_verdict;
    end
endmodule
